// [core/pattern_output_top.sv]
/*
 edge-triggered 12-bit pattern output: event timer, dma channel and
 pattern generator. control bits are plain ports; memory is reached by
 a simple request/response pair. one clock, asynchronous low reset.
*/
module pattern_output_top
   import pattern_pkg::*;
(
   input  wire logic               clock_in,
   input  wire logic               resetn_in,
   input  wire module_stop_t       module_stop_in,       // module stop control
   input  wire logic               counter_start_in,     // counter start control
   input  wire logic               external_count_in,    // external strobe
   input  wire logic               clear_on_a_in,        // counter clear source
   input  wire logic [CNT_W-1:0]   compare_a_value_in,   // compare value
   input  wire logic               compare_pin_en_in,    // timer pin output enable
   input  wire logic               timer_irq_enable_in,  // compare-a irq enable
   input  wire logic               flag_clear_in,        // flag clear pulse
   input  wire logic [TRIG_W-1:0]  output_trigger_in,    // trigger select
   input  wire out_mode_t          output_mode_in,       // mode select
   input  wire logic [7:0]         next_enable_high_in,  // enable upper byte
   input  wire logic [7:0]         next_enable_low_in,   // enable lower byte
   input  wire logic               data_write_in,        // software data write
   input  wire logic [WORD_W-1:0]  output_data_in,       // initial output data
   input  wire logic               next_write_in,        // software next write
   input  wire logic [WORD_W-1:0]  next_value_in,        // next-data word
   input  wire logic               dma_enable_in,        // dma channel enable
   input  wire logic               dma_end_irq_en_in,    // transfer-end irq en
   input  wire logic               dma_load_in,          // load dma setup
   input  wire logic [ADDR_W-1:0]  dma_memory_address_in,// table start
   input  wire logic [XCNT_W-1:0]  dma_transfer_count_in,// transfers
   output mem_req_t                mem_req_out,          // memory read
   input  wire mem_rsp_t           mem_rsp_in,           // memory answer
   output logic [OUT_W-1:0]        pattern_out,          // output pins
   output logic                    compare_pin_out,      // timer pin level
   output logic [CNT_W-1:0]        event_counter_out,    // counter value
   output logic                    compare_flag_out,     // compare-a flag
   output logic                    overflow_flag_out,    // overflow flag
   output logic                    compare_a_irq_out,    // compare-a irq
   output logic                    dma_end_irq_out,      // transfer end irq
   output logic [XCNT_W-1:0]       dma_remaining_out     // transfers left
);
   import pattern_pkg::*;

   // ------------------------------------------------------------
   // timer
   // ------------------------------------------------------------
   logic             match_a;       // compare-a match pulse
   logic [CNT_W-1:0] cnt_w;
   logic             fa_w, fo_w, irq_w;
   logic             pin_q;

   event_timer u_timer (
      .clock_in     (clock_in),
      .resetn_in    (resetn_in),
      .stop_in      (module_stop_in.stop_timer),
      .start_in     (counter_start_in),
      .ext_count_in (external_count_in),
      .clr_on_a_in  (clear_on_a_in),
      .compare_a_in (compare_a_value_in),
      .irq_en_a_in  (timer_irq_enable_in),
      .flag_clr_in  (flag_clear_in),
      .match_out    (match_a),
      .count_out    (cnt_w),
      .flag_a_out   (fa_w),
      .flag_ov_out  (fo_w),
      .irq_out      (irq_w)
   );

   // compare pin toggles on match only when enabled; internal trigger always
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_q <= 1'b0;
      end else if (match_a && compare_pin_en_in) begin
         pin_q <= ~pin_q;
      end
   end

   // ------------------------------------------------------------
   // trigger selection
   // ------------------------------------------------------------
   wire pg_trigger = match_a & (output_trigger_in == TRIG_CH0)
                     & ~module_stop_in.stop_pattern;

   // ------------------------------------------------------------
   // dma channel
   // ------------------------------------------------------------
   logic              dma_wr;
   logic [WORD_W-1:0] dma_data;

   dma_word_channel u_dma (
      .clock_in      (clock_in),
      .resetn_in     (resetn_in),
      .stop_in       (module_stop_in.stop_dma),
      .enable_in     (dma_enable_in),
      .end_irq_en_in (dma_end_irq_en_in),
      .load_in       (dma_load_in),
      .src_addr_in   (dma_memory_address_in),
      .xfer_count_in (dma_transfer_count_in),
      .trigger_in    (match_a),
      .req_out       (mem_req_out),
      .rsp_in        (mem_rsp_in),
      .wr_out        (dma_wr),
      .wr_data_out   (dma_data),
      .remain_out    (dma_remaining_out),
      .end_irq_out   (dma_end_irq_out)
   );

   // ------------------------------------------------------------
   // pattern generator
   // ------------------------------------------------------------
   logic [WORD_W-1:0] next_q;      // next value high:low
   logic [WORD_W-1:0] data_q;      // output data high:low
   wire  [WORD_W-1:0] enable_w = {next_enable_high_in, next_enable_low_in};
   wire  [WORD_W-1:0] upd_w;       // per-bit updated output data

   // per bit: enabled bits take next-data on a trigger
   genvar b;
   generate
      for (b = 0; b < WORD_W; b++) begin : g_bit
         assign upd_w[b] = (pg_trigger && enable_w[b]) ? next_q[b] : data_q[b];
      end
   endgenerate

   // next-data staging; dma write lands one cycle after the memory answer, after the trigger has passed
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         next_q <= WORD_RESET;
      end else if (dma_wr) begin
         next_q <= dma_data;
      end else if (next_write_in) begin
         next_q <= next_value_in;
      end
   end

   // output data: trigger copies in normal mode, software write otherwise
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_q <= WORD_RESET;
      end else if (pg_trigger && output_mode_in == MODE_NORMAL) begin
         data_q <= upd_w;
      end else if (data_write_in) begin
         data_q <= output_data_in;
      end
   end

   // groups 2..0 drive the twelve pins
   assign pattern_out       = data_q[OUT_W-1:0];
   assign compare_pin_out   = pin_q;
   assign event_counter_out = cnt_w;
   assign compare_flag_out  = fa_w;
   assign overflow_flag_out = fo_w;
   assign compare_a_irq_out = irq_w;

   a_trig_copy: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (pg_trigger && output_mode_in == MODE_NORMAL) |=>
      ((data_q & $past(enable_w)) == ($past(next_q) & $past(enable_w))))
      else $error("trigger did not copy");
   a_disabled_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (pg_trigger && !data_write_in) |=>
      ((data_q & ~$past(enable_w)) == ($past(data_q) & ~$past(enable_w))))
      else $error("disabled bit moved");
   a_stop_timer: assert property (@(posedge clock_in) disable iff (!resetn_in)
      module_stop_in.stop_timer |=> !match_a) else $error("timer ran stopped");
   a_pin_quiet: assert property (@(posedge clock_in) disable iff (!resetn_in)
      !compare_pin_en_in |=> $stable(pin_q)) else $error("pin moved");
endmodule

// [core/pattern_pkg.sv]
/*
 package for the edge-triggered pattern output block: widths, reset values,
 field positions and enumerations shared by all three design files.
 assumes a single synchronous clock domain and an active-low reset.
*/
package pattern_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int CNT_W    = 16;            // event counter width
   localparam int OUT_W    = 12;            // pattern output pins
   localparam int WORD_W   = 16;            // next-data word width
   localparam int ADDR_W   = 24;            // dma memory address width
   localparam int XCNT_W   = 16;            // dma transfer count width
   localparam int GROUP_W  = 4;             // bits per output group
   localparam int TRIG_W   = 2;             // trigger select width

   // ------------------------------------------------------------
   // constants
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0]  CNT_RESET   = 16'h0000;  // counter reset value
   localparam logic [CNT_W-1:0]  CNT_ONE     = 16'h0001;  // count step
   localparam logic [CNT_W-1:0]  CNT_MAX     = 16'hFFFF;  // overflow point
   localparam logic [ADDR_W-1:0] ADDR_STEP   = 24'h000002; // word address step
   localparam logic [XCNT_W-1:0] XCNT_ONE    = 16'h0001;  // last transfer count
   localparam logic [WORD_W-1:0] WORD_RESET  = 16'h0000;  // next-data reset
   localparam logic [TRIG_W-1:0] TRIG_CH0    = 2'h0;      // timer channel 0
   localparam logic [ADDR_W-1:0] NEXT_HIGH_ADDR = 24'hFFFF4C; // high next-data address

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic {
      MODE_NORMAL,
      MODE_NONOVERLAP
   } out_mode_t;

   typedef struct packed {
      logic                 stop_timer;   // module stop, timer
      logic                 stop_pattern; // module stop, pattern generator
      logic                 stop_dma;     // module stop, dma
   } module_stop_t;

   typedef struct packed {
      logic                 valid;        // memory read request
      logic [ADDR_W-1:0]    addr;         // source word address
      logic [ADDR_W-1:0]    dest;         // fixed destination address
   } mem_req_t;

   typedef struct packed {
      logic                 valid;        // read data returned
      logic [WORD_W-1:0]    data;         // word read
   } mem_rsp_t;

endpackage

// [core/event_timer.sv]
/*
 event counter with compare-a clear, flags and compare-a interrupt.
 counts rising edges of a synchronous external input while started.
*/
module event_timer
   import pattern_pkg::*;
(
   input  wire logic             clock_in,
   input  wire logic             resetn_in,
   input  wire logic             stop_in,       // module stop
   input  wire logic             start_in,      // counter start control
   input  wire logic             ext_count_in,  // external count input
   input  wire logic             clr_on_a_in,   // clear on compare-a match
   input  wire logic [CNT_W-1:0] compare_a_in,  // compare value
   input  wire logic             irq_en_a_in,   // compare-a irq enable
   input  wire logic             flag_clr_in,   // clear flags pulse
   output logic                  match_out,     // compare-a match pulse
   output logic [CNT_W-1:0]      count_out,     // counter value
   output logic                  flag_a_out,    // compare-a flag
   output logic                  flag_ov_out,   // overflow flag
   output logic                  irq_out        // compare-a irq
);
   import pattern_pkg::*;

   // ------------------------------------------------------------
   // edge detect and counting
   // ------------------------------------------------------------
   logic             ext_q;       // previous count input level
   logic [CNT_W-1:0] cnt_q;       // event counter
   logic             match_q;
   logic             fa_q, fo_q, irq_q;

   wire run      = ~stop_in & start_in;
   wire edge_hit = run & ext_count_in & ~ext_q;
   wire hit_a    = edge_hit & (cnt_q == compare_a_in);
   wire ovf      = edge_hit & (cnt_q == CNT_MAX);

   // counter advances on external rising edges, clears on compare-a
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ext_q <= 1'b0;
         cnt_q <= CNT_RESET;
         match_q <= 1'b0;
      end else begin
         ext_q   <= ext_count_in;
         match_q <= hit_a;
         if (hit_a && clr_on_a_in) begin
            cnt_q <= CNT_RESET;
         end else if (edge_hit) begin
            cnt_q <= cnt_q + CNT_ONE;
         end
      end
   end

   // sticky flags: a set wins over a clear in the same cycle
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fa_q  <= 1'b0;
         fo_q  <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         fa_q  <= hit_a | (fa_q & ~flag_clr_in);
         fo_q  <= ovf | (fo_q & ~flag_clr_in);
         irq_q <= (hit_a | (fa_q & ~flag_clr_in)) & irq_en_a_in;
      end
   end

   assign match_out   = match_q;
   assign count_out   = cnt_q;
   assign flag_a_out  = fa_q;
   assign flag_ov_out = fo_q;
   assign irq_out     = irq_q;

   a_irq_gated: assert property (@(posedge clock_in) disable iff (!resetn_in)
      irq_q |-> fa_q) else $error("irq without flag");
   a_count_clear: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (hit_a && clr_on_a_in) |=> (cnt_q == CNT_RESET))
      else $error("counter not cleared");
endmodule

// [core/dma_word_channel.sv]
/*
 single dma channel: sequential word transfers from an incrementing
 memory address to a fixed destination, one per activation.
 assumes memory answers each read with one response pulse.
*/
module dma_word_channel
   import pattern_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              resetn_in,
   input  wire logic              stop_in,        // module stop
   input  wire logic              enable_in,      // channel enable
   input  wire logic              end_irq_en_in,  // transfer-end irq enable
   input  wire logic              load_in,        // load address and count
   input  wire logic [ADDR_W-1:0] src_addr_in,    // table start address
   input  wire logic [XCNT_W-1:0] xfer_count_in,  // number of transfers
   input  wire logic              trigger_in,     // activation pulse
   output mem_req_t               req_out,        // memory read request
   input  wire mem_rsp_t          rsp_in,         // memory read answer
   output logic                   wr_out,         // write to next-data
   output logic [WORD_W-1:0]      wr_data_out,    // word written
   output logic [XCNT_W-1:0]      remain_out,     // transfers left
   output logic                   end_irq_out     // transfer end irq
);
   import pattern_pkg::*;

   // ------------------------------------------------------------
   // channel state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {IDLE, READ, DONE} dma_state_t;
   dma_state_t        st_q;
   logic [ADDR_W-1:0] mar_q;
   logic [XCNT_W-1:0] cnt_q;
   logic              wr_q, end_q;
   logic [WORD_W-1:0] data_q;
   mem_req_t          req_q;

   wire active = enable_in & ~stop_in;
   wire last   = (cnt_q == XCNT_ONE);

   // sequencer: one word per trigger, address up, destination fixed
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q   <= IDLE;
         mar_q  <= '0;
         cnt_q  <= '0;
         wr_q   <= 1'b0;
         data_q <= WORD_RESET;
         req_q  <= '0;
         end_q  <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         if (load_in) begin
            mar_q <= src_addr_in;
            cnt_q <= xfer_count_in;
            end_q <= 1'b0;
            st_q  <= IDLE;
         end else begin
            case (st_q)
               IDLE: begin
                  if (active && trigger_in && cnt_q != '0) begin
                     req_q <= '{valid: 1'b1, addr: mar_q, dest: NEXT_HIGH_ADDR};
                     st_q  <= READ;
                  end
               end
               READ: begin
                  req_q.valid <= 1'b0;
                  if (rsp_in.valid) begin
                     wr_q   <= 1'b1;
                     data_q <= rsp_in.data;
                     mar_q  <= mar_q + ADDR_STEP;
                     cnt_q  <= cnt_q - XCNT_ONE;
                     st_q   <= last ? DONE : IDLE;
                     end_q  <= last & end_irq_en_in;
                  end
               end
               default: begin
                  st_q <= DONE;
               end
            endcase
         end
      end
   end

   assign req_out     = req_q;
   assign wr_out      = wr_q;
   assign wr_data_out = data_q;
   assign remain_out  = cnt_q;
   assign end_irq_out = end_q;

   a_end_last: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $rose(end_q) |-> (cnt_q == '0) && $past(end_irq_en_in))
      else $error("end irq before last");
   a_mar_step: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (st_q == READ && rsp_in.valid && !load_in) |=> mar_q == $past(mar_q) + ADDR_STEP)
      else $error("address not stepped");
endmodule

// [verification/strobe_source.sv]
/*
 far-side model: the external strobe source that drives the count input.
 assumes the bench asks for one strobe by a one-cycle request pulse and
 spaces its requests wider than the memory latency.
*/
module strobe_source (
   input  wire logic clock_in,   // system clock
   input  wire logic resetn_in,  // asynchronous reset, active low
   input  wire logic fire_in,    // request one strobe
   output logic      strobe_out  // strobe to the count input
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // strobe shaping
   // ------------------------------------------------------------
   logic [1:0] hold_q;  // cycles of high level left

   // high for two cycles, so every strobe is one clean rising edge
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hold_q <= 2'h0;
      end else if (fire_in) begin
         hold_q <= 2'h2;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end

   // idle level is low between strobes
   assign strobe_out = (hold_q != 2'h0);
endmodule

// [verification/testbench.sv]
/*
 self-checking bench for pattern_output_top: software setup through ports,
 a memory model holding the pattern table, strobes from strobe_source.
 assumes one 200 MHz clock and inputs changed 1 ns after each rising edge.
*/
module testbench;
   import pattern_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] TABLE_BASE = 24'hFFEC00;  // pattern table start
   logic clock_in = 1'b0, resetn_in = 1'b0, fire = 1'b0, strobe;
   module_stop_t stop = 3'h0;
   logic start = 1'b0, clr_a = 1'b1, irq_en = 1'b0, flag_clr = 1'b0;
   logic pin_en = 1'b0;                 // compare pin output enable
   logic [TRIG_W-1:0] trig = TRIG_CH0;  // pattern trigger select
   logic dwr = 1'b0, nwr = 1'b0, dma_en = 1'b0, dma_irq_en = 1'b0, dma_load = 1'b0;
   logic [CNT_W-1:0] cmp = 16'h0000, counter, remain;
   logic [7:0] en_h = 8'h00, en_l = 8'h00;
   logic [WORD_W-1:0] dval = 16'h0000, nval = 16'h0000;
   logic [WORD_W-1:0] tbl [15];  // pattern table in memory
   out_mode_t mode = MODE_NORMAL;
   mem_req_t req;
   mem_rsp_t rsp = '0;
   logic [OUT_W-1:0] pattern;
   logic pin, flag, ovf, irq, end_irq;
   logic [1:0] rsp_wait = 2'h0;  // cycles until memory answers
   int xfers = 0, fails = 0, samples_checked = 0, cycles = 0;

   always #2.5 clock_in = ~clock_in;

   pattern_output_top i_pattern_output_top (
      .clock_in(clock_in), .resetn_in(resetn_in), .module_stop_in(stop),
      .counter_start_in(start), .external_count_in(strobe), .clear_on_a_in(clr_a),
      .compare_a_value_in(cmp), .compare_pin_en_in(pin_en), .timer_irq_enable_in(irq_en),
      .flag_clear_in(flag_clr), .output_trigger_in(trig), .output_mode_in(mode),
      .next_enable_high_in(en_h), .next_enable_low_in(en_l), .data_write_in(dwr),
      .output_data_in(dval), .next_write_in(nwr), .next_value_in(nval),
      .dma_enable_in(dma_en), .dma_end_irq_en_in(dma_irq_en), .dma_load_in(dma_load),
      .dma_memory_address_in(TABLE_BASE), .dma_transfer_count_in(16'h000F),
      .mem_req_out(req), .mem_rsp_in(rsp), .pattern_out(pattern), .compare_pin_out(pin),
      .event_counter_out(counter), .compare_flag_out(flag), .overflow_flag_out(ovf),
      .compare_a_irq_out(irq), .dma_end_irq_out(end_irq), .dma_remaining_out(remain));

   strobe_source i_strobe_source (
      .clock_in(clock_in), .resetn_in(resetn_in), .fire_in(fire), .strobe_out(strobe));

   // ------------------------------------------------------------
   // compare, timing and closing tasks
   // ------------------------------------------------------------
   task automatic check_vec(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic tick();
      @(posedge clock_in);
      #1;
   endtask

   // one strobe, then long enough for the dma word to land
   task automatic send_strobe();
      fire = 1'b1;
      tick();
      fire = 1'b0;
      repeat (9) tick();
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // memory model and hang guard
   // ------------------------------------------------------------
   // answers each read two cycles later; data churns while idle
   always @(posedge clock_in) begin
      #1;
      rsp.valid = (rsp_wait == 2'h1);
      if (rsp_wait != 2'h0) rsp_wait = rsp_wait - 2'h1;
      else if (!rsp.valid) rsp.data = ~rsp.data;
      if (req.valid === 1'b1) begin
         check_vec(req.addr, TABLE_BASE + ADDR_W'(2 * xfers));
         check_vec(req.dest, NEXT_HIGH_ADDR);
         rsp.data = tbl[xfers % 15];
         rsp_wait = 2'h2;
         xfers++;
      end
   end

   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      for (int k = 0; k < 15; k++) tbl[k] = 16'hF0F0 + WORD_W'(k * 16'h0111);
      repeat (10) tick();
      resetn_in = 1'b1;
      check_vec(ADDR_W'(pattern), 24'h000000);
      // initial data, next data and dma setup before the counter starts
      cmp = 16'h0000;
      en_h = 8'h0F;
      en_l = 8'hFF;
      dwr = 1'b1;
      nval = 16'h0FFF;
      nwr = 1'b1;
      dma_load = 1'b1;
      dma_en = 1'b1;
      dma_irq_en = 1'b1;
      irq_en = 1'b1;
      tick();
      dwr = 1'b0;
      nwr = 1'b0;
      dma_load = 1'b0;
      tick();
      check_vec(ADDR_W'(remain), 24'h00000F);
      start = 1'b1;
      tick();
      // fifteen transfers, then two strobes after the count ran out
      for (int k = 1; k <= 17; k++) begin
         send_strobe();
         check_vec(ADDR_W'(pattern), (k == 1) ? 24'h000FFF :
                   ADDR_W'(tbl[(k > 16) ? 14 : k - 2][11:0]));
         check_vec(ADDR_W'(counter), 24'h000000);
         check_bit(flag, 1'b1);
         check_bit(irq, 1'b1);
         check_vec(ADDR_W'(remain), ADDR_W'((k >= 15) ? 0 : 15 - k));
         check_vec(ADDR_W'(xfers), ADDR_W'((k >= 15) ? 15 : k));
         check_bit(end_irq, k >= 15);
      end
      // flag clear, then a match with the interrupt masked
      flag_clr = 1'b1;
      tick();
      flag_clr = 1'b0;
      irq_en = 1'b0;
      tick();
      check_bit(flag, 1'b0);
      send_strobe();
      check_bit(flag, 1'b1);
      check_bit(irq, 1'b0);
      irq_en = 1'b1;
      repeat (2) tick();
      check_bit(irq, 1'b1);
      // direct data write, then a trigger with only group 0 enabled
      dval = 16'hFABC;
      dwr = 1'b1;
      tick();
      dwr = 1'b0;
      tick();
      check_vec(ADDR_W'(pattern), 24'h000ABC);
      nval = 16'h0555;
      nwr = 1'b1;
      en_h = 8'h00;
      en_l = 8'h0F;
      tick();
      nwr = 1'b0;
      send_strobe();
      check_vec(ADDR_W'(pattern), 24'h000AB5);
      en_h = 8'h0F;
      en_l = 8'hFF;
      // stopped timer and non-overlap mode leave the pins alone
      stop.stop_timer = 1'b1;
      nval = 16'h0123;
      nwr = 1'b1;
      tick();
      nwr = 1'b0;
      send_strobe();
      check_vec(ADDR_W'(pattern), 24'h000AB5);
      stop.stop_timer = 1'b0;
      mode = MODE_NONOVERLAP;
      send_strobe();
      check_vec(ADDR_W'(pattern), 24'h000AB5);
      mode = MODE_NORMAL;
      send_strobe();
      check_vec(ADDR_W'(pattern), 24'h000123);
      stop.stop_pattern = 1'b1;
      nval = 16'h0456;
      nwr = 1'b1;
      tick();
      nwr = 1'b0;
      send_strobe();
      check_vec(ADDR_W'(pattern), 24'h000123);
      stop.stop_pattern = 1'b0;
      // counting without compare clear
      clr_a = 1'b0;
      cmp = 16'h0005;
      repeat (3) send_strobe();
      check_vec(ADDR_W'(counter), 24'h000003);
      check_bit(ovf, 1'b0);
      check_bit(pin, 1'b0);
      // a match with another trigger source selected and the pin disabled
      cmp = 16'h0003;
      trig = 2'h1;
      send_strobe();
      check_vec(ADDR_W'(pattern), 24'h000123);
      check_vec(ADDR_W'(counter), 24'h000004);
      check_bit(pin, 1'b0);
      // pin enabled: the next match toggles it and triggers the pins
      cmp = 16'h0004;
      trig = TRIG_CH0;
      pin_en = 1'b1;
      send_strobe();
      check_bit(pin, 1'b1);
      check_vec(ADDR_W'(pattern), 24'h000456);
      conclude();
   end
endmodule
